// *** inc/adc_ovr_pkg.sv ***
// constants shared by the over-range detector and its bench
package adc_ovr_pkg;
  localparam int NUM_CH = 4;
  localparam int SAMPLE_W = 9;
  localparam int MAG_W = 8;
  localparam int SEL_W = 3;
  localparam int CNT_W = 11;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // sample clock period in ns, equal to pclk
  localparam int SAMPLE_CLK_PERIOD_NS = 10;
  // hold length is this base shifted left by the length select
  localparam logic [CNT_W-1:0] HOLD_BASE_CYCLES = 11'h008;
  // most negative code, folded onto full scale
  localparam logic [SAMPLE_W-1:0] MOST_NEG_CODE = 9'h100;
  localparam logic [MAG_W-1:0] MAG_FULL = 8'hff;
  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] THRESH_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h008;
  localparam logic [ADDR_W-1:0] MASK_OFFSET = 12'h00c;
  localparam logic [ADDR_W-1:0] LIVE_OFFSET = 12'h010;
  // control field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  // live register field positions
  localparam int LIVE_OUT_LSB = 0;
  localparam int LIVE_EN_BIT = 4;
  // values after reset
  localparam logic [SEL_W:0] CTRL_RESET = 4'h0;
  localparam logic [MAG_W-1:0] THRESH_RESET = 8'he4;
  localparam logic [NUM_CH-1:0] STATUS_RESET = 4'h0;
  localparam logic [NUM_CH-1:0] MASK_RESET = 4'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 11'h000;
endpackage

// *** verilog/adc_over_range_detector.sv ***
// over-range detector: per-channel magnitude compare, hold counters, apb registers
`timescale 1ns/1ns
// Function
// RULE_01: each sample is captured on the rising sample clock edge.
// RULE_02: samples are 9-bit two's complement, -256 to 255.
// RULE_03: magnitude is the 8-bit absolute value; -256 and 255 both give 255.
// RULE_04: monitoring runs only while the enable bit is one.
// RULE_05: a channel hits when magnitude is at least the threshold.
// RULE_06: each channel drives its own over-range output pin.
// RULE_07: output holds 8 to 1024 cycles after the last hit, by 3-bit select.
// RULE_08: software should set threshold near full scale and reduce gain on hits.
// RULE_09: downstream logic decides when over-range ended before raising gain.
// RULE_10: a new hit restarts the count; disabled means all outputs low; code drives only the pins low, irq follows held status.
module adc_over_range_detector
  import adc_ovr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SAMPLE_W-1:0] sample_a,
  input wire logic [SAMPLE_W-1:0] sample_b,
  input wire logic [SAMPLE_W-1:0] sample_c,
  input wire logic [SAMPLE_W-1:0] sample_d,
  output logic over_range_out_a,
  output logic over_range_out_b,
  output logic over_range_out_c,
  output logic over_range_out_d,
  output logic irq
);

  logic [SAMPLE_W-1:0] sample_in [NUM_CH];
  logic [SAMPLE_W-1:0] sample_reg [NUM_CH];
  logic [SAMPLE_W-1:0] sample_next [NUM_CH];
  logic [MAG_W-1:0] mag [NUM_CH];
  logic [CNT_W-1:0] cnt_reg [NUM_CH];
  logic [CNT_W-1:0] cnt_next [NUM_CH];
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] out_reg;
  logic [NUM_CH-1:0] out_next;
  logic [SEL_W:0] ctrl_reg;
  logic [SEL_W:0] ctrl_next;
  logic [MAG_W-1:0] thresh_reg;
  logic [MAG_W-1:0] thresh_next;
  logic [NUM_CH-1:0] status_reg;
  logic [NUM_CH-1:0] status_next;
  logic [NUM_CH-1:0] mask_reg;
  logic [NUM_CH-1:0] mask_next;
  logic irq_reg;
  logic irq_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic monitor_en;
  logic [SEL_W-1:0] hold_sel;
  logic [CNT_W-1:0] hold_len;
  logic xfer_done;
  logic wr_done;
  logic status_read;
  logic addr_mapped;

  assign sample_in[0] = sample_a;
  assign sample_in[1] = sample_b;
  assign sample_in[2] = sample_c;
  assign sample_in[3] = sample_d;

  assign monitor_en = ctrl_reg[CTRL_EN_BIT];
  assign hold_sel = ctrl_reg[CTRL_SEL_LSB +: SEL_W];
  assign hold_len = HOLD_BASE_CYCLES << hold_sel; // RULE_07

  // per-channel datapath
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      logic cut_reg;
      logic cut_next;
      always_comb
      begin
        sample_next[gi] = sample_in[gi]; // RULE_01
        // saturating absolute value keeps -256 on full scale
        if (!sample_reg[gi][SAMPLE_W-1])
          mag[gi] = sample_reg[gi][MAG_W-1:0]; // RULE_02
        else if (sample_reg[gi] == MOST_NEG_CODE)
          mag[gi] = MAG_FULL; // RULE_03
        else
          mag[gi] = MAG_W'(-sample_reg[gi]); // RULE_03
        hit[gi] = monitor_en && (mag[gi] >= thresh_reg); // RULE_04 RULE_05
        if (!monitor_en)
          cnt_next[gi] = CNT_RESET; // RULE_10
        else if (hit[gi])
          cnt_next[gi] = hold_len; // RULE_10
        else if (cnt_reg[gi] != CNT_RESET)
          cnt_next[gi] = cnt_reg[gi] - 11'h001; // RULE_07
        else
          cnt_next[gi] = CNT_RESET;
        out_next[gi] = (cnt_next[gi] != CNT_RESET); // RULE_06
        // a disable cuts a running pulse short; the pulse check allows for it
        if (!monitor_en)
          cut_next = 1'b1;
        else if (hit[gi])
          cut_next = 1'b0;
        else
          cut_next = cut_reg;
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sample_reg[gi] <= '0;
          cnt_reg[gi] <= CNT_RESET;
          out_reg[gi] <= 1'b0;
          cut_reg <= 1'b0;
        end
        else
        begin
          sample_reg[gi] <= sample_next[gi];
          cnt_reg[gi] <= cnt_next[gi];
          out_reg[gi] <= out_next[gi];
          cut_reg <= cut_next;
        end
      end

      property p_capture;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> sample_reg[gi] == $past(sample_in[gi]);
      endproperty
      a_capture: assert property (p_capture) // RULE_01
        else $error("sample not captured on the clock edge");

      property p_neg_mag;
        @(posedge pclk) disable iff (!presetn)
        (sample_reg[gi][SAMPLE_W-1] && sample_reg[gi] != MOST_NEG_CODE)
          |-> (mag[gi] == MAG_W'(~sample_reg[gi] + 9'h001));
      endproperty
      a_neg_mag: assert property (p_neg_mag) // RULE_02
        else $error("negative sample magnitude wrong");

      property p_most_neg;
        @(posedge pclk) disable iff (!presetn)
        (sample_reg[gi] == MOST_NEG_CODE) |-> (mag[gi] == 8'hff);
      endproperty
      a_most_neg: assert property (p_most_neg) // RULE_03
        else $error("most negative code not folded to full scale");

      property p_hit_pulse;
        @(posedge pclk) disable iff (!presetn)
        (monitor_en && mag[gi] >= thresh_reg)
          |=> (out_reg[gi] || cut_reg) [*8];
      endproperty
      a_hit_pulse: assert property (p_hit_pulse) // RULE_05
        else $error("hit did not hold output for eight cycles");

      property p_disabled_low;
        @(posedge pclk) disable iff (!presetn)
        !monitor_en |=> !out_reg[gi];
      endproperty
      a_disabled_low: assert property (p_disabled_low) // RULE_04
        else $error("output high while monitoring disabled");

      property p_restart;
        @(posedge pclk) disable iff (!presetn)
        hit[gi] |=> (cnt_reg[gi] == $past(hold_len)) && out_reg[gi];
      endproperty
      a_restart: assert property (p_restart) // RULE_10
        else $error("hit did not restart the hold count");

      property p_count_down;
        @(posedge pclk) disable iff (!presetn)
        (monitor_en && !hit[gi] && cnt_reg[gi] != 11'h000)
          |=> (cnt_reg[gi] == $past(cnt_reg[gi]) - 11'h001);
      endproperty
      a_count_down: assert property (p_count_down) // RULE_07
        else $error("hold count did not step down");

      property p_pin_end;
        @(posedge pclk) disable iff (!presetn)
        $fell(out_reg[gi]) |-> ($past(cnt_reg[gi]) == 11'h001) || !$past(monitor_en);
      endproperty
      a_pin_end: assert property (p_pin_end) // RULE_06
        else $error("output dropped before hold length expired");

      property p_status_set;
        @(posedge pclk) disable iff (!presetn)
        (monitor_en && mag[gi] >= thresh_reg) |=> status_reg[gi];
      endproperty
      a_status_set: assert property (p_status_set) // RULE_05
        else $error("hit did not set the status bit");

      property p_off_no_status;
        @(posedge pclk) disable iff (!presetn)
        (!monitor_en && !status_reg[gi]) |=> !status_reg[gi];
      endproperty
      a_off_no_status: assert property (p_off_no_status) // RULE_04
        else $error("status bit set while monitoring disabled");

      property p_below_low;
        @(posedge pclk) disable iff (!presetn)
        (mag[gi] < thresh_reg && cnt_reg[gi] == 11'h000) |=> !out_reg[gi];
      endproperty
      a_below_low: assert property (p_below_low) // RULE_05
        else $error("output raised by a sample below the threshold");
    end
  endgenerate

  assign over_range_out_a = out_reg[0];
  assign over_range_out_b = out_reg[1];
  assign over_range_out_c = out_reg[2];
  assign over_range_out_d = out_reg[3];

  // apb slave: pready rises the cycle after setup, so every access has one wait-free
  // access cycle; read data is built from the setup address
  assign xfer_done = psel && penable && pready_reg;
  assign wr_done = xfer_done && pwrite && !pslverr_reg && pstrb[0];
  assign status_read = xfer_done && !pwrite && (paddr == STATUS_OFFSET);
  assign addr_mapped = (paddr == CTRL_OFFSET) || (paddr == THRESH_OFFSET)
    || (paddr == STATUS_OFFSET) || (paddr == MASK_OFFSET) || (paddr == LIVE_OFFSET);

  always_comb
  begin
    pready_next = psel && !penable;
    pslverr_next = psel && !penable && !addr_mapped;
    prdata_next = '0;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        CTRL_OFFSET: prdata_next[SEL_W:0] = ctrl_reg;
        THRESH_OFFSET: prdata_next[MAG_W-1:0] = thresh_reg;
        STATUS_OFFSET: prdata_next[NUM_CH-1:0] = status_reg;
        MASK_OFFSET: prdata_next[NUM_CH-1:0] = mask_reg;
        LIVE_OFFSET:
        begin
          prdata_next[LIVE_OUT_LSB +: NUM_CH] = out_reg;
          prdata_next[LIVE_EN_BIT] = monitor_en;
        end
        default: prdata_next = '0;
      endcase
    end
    ctrl_next = ctrl_reg;
    thresh_next = thresh_reg;
    mask_next = mask_reg;
    if (wr_done && paddr == CTRL_OFFSET)
      ctrl_next = pwdata[SEL_W:0];
    if (wr_done && paddr == THRESH_OFFSET)
      thresh_next = pwdata[MAG_W-1:0];
    if (wr_done && paddr == MASK_OFFSET)
      mask_next = pwdata[NUM_CH-1:0];
    // clear only what the read reported, so a hit during setup is not lost
    status_next = (status_reg & ~(prdata_reg[NUM_CH-1:0] & {NUM_CH{status_read}})) | hit;
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      ctrl_reg <= CTRL_RESET;
      thresh_reg <= THRESH_RESET;
      mask_reg <= MASK_RESET;
      status_reg <= STATUS_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
      ctrl_reg <= ctrl_next;
      thresh_reg <= thresh_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      irq_reg <= irq_next;
    end
  end

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |-> irq_reg == |(status_reg & mask_reg);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt does not follow masked status");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
    pready_reg |=> !pready_reg;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  assign irq = irq_reg;

endmodule // adc_over_range_detector

// *** bench/gain_ctrl_model.sv ***
// downstream gain-control model watching the over-range pins
`timescale 1ns/1ns
module gain_ctrl_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] over_range,
  input wire logic [8:0] sample,
  output logic gain_low
);
  logic [3:0] quiet_reg;
  // gain returns only after its own look at the samples, not when the pin drops
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      gain_low <= 1'b0;
      quiet_reg <= 4'h0;
    end
    else if (|over_range)
    begin
      gain_low <= 1'b1;
      quiet_reg <= 4'h0;
    end
    else if (sample[8:4] == 5'h00 || sample[8:4] == 5'h1f)
    begin
      quiet_reg <= quiet_reg + 4'h1;
      if (quiet_reg == 4'hf)
        gain_low <= 1'b0;
    end
    else
      quiet_reg <= 4'h0;
endmodule // gain_ctrl_model

// *** bench/adc_over_range_detector_tb_top.sv ***
// self-checking bench for the over-range detector
`timescale 1ns/1ns
module adc_over_range_detector_tb_top;
  import adc_ovr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, gain_low;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [SAMPLE_W-1:0] smp [NUM_CH];
  wire [3:0] pins;
  int miscompares, n_checks;
  adc_over_range_detector uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .sample_a(smp[0]), .sample_b(smp[1]),
    .sample_c(smp[2]), .sample_d(smp[3]), .over_range_out_a(pins[0]),
    .over_range_out_b(pins[1]), .over_range_out_c(pins[2]), .over_range_out_d(pins[3]), .irq);
  gain_ctrl_model far (.pclk, .presetn, .over_range(pins), .sample(smp[0]), .gain_low);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one access cycle: ready comes on the first edge after setup
    chk(k, 1);
  endtask
  // one-cycle sample; ends on the capturing edge
  task automatic hit(input int ch, input logic [8:0] code);
    @(posedge pclk);
    smp[ch] <= code;
    @(posedge pclk);
    smp[ch] <= 9'h000;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic held(input int ch, input int exp);
    int c;
    c = 0;
    settle(1);
    while (pins[ch] === 1'b1 && c < 1100)
    begin
      c++;
      settle(1);
    end
    chk(c, exp);
  endtask
  task automatic t_reset();
    logic [ADDR_W-1:0] a [4] = '{CTRL_OFFSET, THRESH_OFFSET, STATUS_OFFSET, MASK_OFFSET};
    logic [DATA_W-1:0] e [4] = '{32'h0, 32'he4, 32'h0, 32'h0};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, a[i], '0);
      chk(rd, e[i]);
    end
    apb(1'b0, 12'h020, '0);
    chk(er, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_mag();
    logic [8:0] code [6] = '{9'h0ff, 9'h0fe, 9'h102, 9'h100, 9'h0fd, 9'h103};
    apb(1'b1, THRESH_OFFSET, 32'hfe);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      hit(0, code[i]);
      settle(1);
      chk(pins[0], i < 4);
      settle(10);
    end
    chk(gain_low, 1'b1);
    settle(20);
    chk(gain_low, 1'b0);
    $display("magnitude test done");
  endtask
  task automatic t_len();
    apb(1'b1, THRESH_OFFSET, 32'he4);
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1, CTRL_OFFSET, (s << 1) | 1);
      hit(1, 9'h0e5);
      held(1, 8 << s);
    end
    apb(1'b1, CTRL_OFFSET, 32'h1);
    hit(1, 9'h11c);
    hit(1, 9'h0e4);
    held(1, 8);
    $display("length test done");
  endtask
  task automatic t_chan();
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      hit(ch, 9'h0ff);
      settle(1);
      chk(pins, 4'h1 << ch);
      held(ch, 7);
    end
    $display("channel test done");
  endtask
  task automatic t_irq();
    apb(1'b1, MASK_OFFSET, 32'h1);
    apb(1'b0, STATUS_OFFSET, '0);
    hit(1, 9'h0ff);
    settle(2);
    chk(irq, 1'b0);
    hit(0, 9'h0ff);
    settle(2);
    chk(irq, 1'b1);
    apb(1'b0, STATUS_OFFSET, '0);
    chk(rd, 32'h3);
    settle(1);
    chk(irq, 1'b0);
    apb(1'b1, CTRL_OFFSET, 32'hf);
    hit(2, 9'h0ff);
    apb(1'b0, LIVE_OFFSET, '0);
    chk(rd, 32'h14);
    apb(1'b1, CTRL_OFFSET, 32'he);
    settle(1);
    chk(pins, 4'h0);
    hit(3, 9'h100);
    settle(1);
    chk(pins, 4'h0);
    apb(1'b0, STATUS_OFFSET, '0);
    chk(rd, 32'h4);
    $display("interrupt test done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    smp = '{default: '0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mag();
    t_len();
    t_chan();
    t_irq();
    close_out();
  end
  // whole run is near 2500 cycles; four times that is ample
  initial
  begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule // adc_over_range_detector_tb_top
